// >>> grading_pkg.sv
// constants, types and notes for the weight grading hold logic
package grading_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] DIFF_OFS = 8'h08;
    localparam logic [7:0] DISPLAY_OFS = 8'h0C;
    localparam logic [7:0] LEVEL_BASE_OFS = 8'h20; // eight levels, 0x20..0x3C
    // control field positions
    localparam int OPMODE_LSB = 0;   // 2 bits
    localparam int PRINT_LSB = 4;    // 2 bits
    localparam int AVG_LSB = 8;      // 4 bits
    localparam int APERTURE_LSB = 12; // 4 bits, tenths of a division
    localparam int CHECK_LSB = 16;   // 2 bits
    // control values
    localparam logic [1:0] OPMODE_NORMAL = 2'h0;
    localparam logic [1:0] OPMODE_GRADE_WEIGHT = 2'h1;
    localparam logic [1:0] OPMODE_GRADE_NUMBER = 2'h2;
    localparam logic [1:0] PRINT_AUTO2 = 2'h2;
    localparam logic [3:0] AVG_EIGHT = 4'h8;
    localparam logic [3:0] APERTURE_HALF = 4'h5;
    localparam logic [1:0] CHECK_SETPOINT = 2'h1;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] LEVEL_RESET = 32'h0000_0000;
    localparam int NUM_LEVELS = 8;
    // timing
    localparam int HOLD_TIME_MS = 2000;
    localparam int CLK_HZ = 40_000_000;
    localparam int HOLD_CYCLES = (CLK_HZ / 1000) * HOLD_TIME_MS;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [1:0] check_mode;
        logic [3:0] aperture;
        logic [3:0] avg;
        logic [1:0] print_mode;
        logic [1:0] opmode;
    } ctrl_s;
endpackage : grading_pkg

// >>> tb.sv
// self-checking testbench for the weight grading hold logic
`timescale 1ns/1ps
`default_nettype none
module tb
    import grading_pkg::*;
;
    // short hold keeps the run brief; every expectation uses this value
    localparam int HOLD_SIM = 20;
    localparam int TIMEOUT_CYCLES = 4000;
    // ----------------------------------------
    // signals and design instance
    // ----------------------------------------
    logic sys_clk, nrst, stable_in, hold_active, accum_enable, config_ok, display_is_grade;
    logic signed [31:0] weight_in;
    logic [NUM_LEVELS-1:0] grade_out;
    logic [23:0] display_digits;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] rd;
    int err_total = 0;
    int comparisons = 0;
    int cycles = 0;

    weight_grading_hold_logic #(.HOLD_COUNT(HOLD_SIM)) DUT (
        .sys_clk(sys_clk), .nrst(nrst), .weight_in(weight_in), .stable_in(stable_in),
        .hold_active(hold_active), .grade_out(grade_out), .accum_enable(accum_enable),
        .config_ok(config_ok), .display_digits(display_digits), .display_is_grade(display_is_grade),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
    );

    // 40 MHz clock
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // watchdog: a hang counts as a mismatch
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == TIMEOUT_CYCLES)
        begin
            err_total = err_total + 1;
            $display("unexpected timeout: expected end before %0d cycles, seen %0d", TIMEOUT_CYCLES, cycles);
            end_of_test();
        end
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons = comparisons + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask : chk

    // payload held until each channel is taken; bready held until bvalid seen
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever
        begin
            @(posedge sys_clk);
            if (!aw_done && s_axi_awready === 1'b1)
            begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready === 1'b1)
            begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid === 1'b1)
            begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
        @(posedge sys_clk);
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever
        begin
            @(posedge sys_clk);
            if (s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1)
            begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
        @(posedge sys_clk);
    endtask : axi_read

    function automatic logic [31:0] ctrl_word(input logic [1:0] op, input logic [1:0] pr, input logic [3:0] av);
        return (32'(op) << OPMODE_LSB) | (32'(pr) << PRINT_LSB) | (32'(av) << AVG_LSB)
            | (32'(APERTURE_HALF) << APERTURE_LSB) | (32'(CHECK_SETPOINT) << CHECK_LSB);
    endfunction : ctrl_word

    // new stable reading after a spell of motion
    task automatic settle(input logic signed [31:0] w);
        weight_in <= w;
        stable_in <= 1'b0;
        repeat (2) @(posedge sys_clk);
        stable_in <= 1'b1;
        repeat (3) @(posedge sys_clk);
    endtask : settle

    // grade by testing levels i*10 from eight downward
    function automatic int exp_grade(input int diff);
        for (int i = NUM_LEVELS; i >= 1; i--)
            if (diff >= i * 10)
                return i;
        return 0;
    endfunction : exp_grade

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_regs();
        chk("hold after reset", 32'h0, {31'h0, hold_active});
        axi_read(CTRL_OFS, rd, resp);
        chk("ctrl reset", CTRL_RESET, rd);
        axi_read(LEVEL_BASE_OFS, rd, resp);
        chk("level reset", LEVEL_RESET, rd);
        // config check needs average 8, half aperture, setpoint mode
        axi_write(CTRL_OFS, ctrl_word(OPMODE_GRADE_WEIGHT, PRINT_AUTO2, AVG_EIGHT), resp);
        axi_read(CTRL_OFS, rd, resp);
        chk("ctrl readback", ctrl_word(OPMODE_GRADE_WEIGHT, PRINT_AUTO2, AVG_EIGHT), rd);
        chk("config_ok", 32'h1, {31'h0, config_ok});
        chk("accum on auto print 2", 32'h1, {31'h0, accum_enable});
        axi_write(CTRL_OFS, ctrl_word(OPMODE_GRADE_NUMBER, 2'h1, 4'h4), resp);
        chk("accum other print", 32'h0, {31'h0, accum_enable});
        chk("config avg 4", 32'h0, {31'h0, config_ok});
        axi_write(8'h10, 32'h1234_5678, resp);
        chk("unmapped write resp", 32'(RESP_SLVERR), 32'(resp));
        axi_read(8'h10, rd, resp);
        chk("unmapped read resp", 32'(RESP_SLVERR), 32'(resp));
        axi_write(STATUS_OFS, 32'hFFFF_FFFF, resp);
        chk("status write resp", 32'(RESP_OKAY), 32'(resp));
        for (int i = 0; i < NUM_LEVELS; i++)
            axi_write(LEVEL_BASE_OFS + 8'(4 * i), 32'((i + 1) * 10), resp);
        $display("test_regs done");
    endtask : test_regs

    task automatic test_normal();
        axi_write(CTRL_OFS, ctrl_word(OPMODE_NORMAL, PRINT_AUTO2, AVG_EIGHT), resp);
        settle(100);
        settle(300);
        chk("hold in normal mode", 32'h0, {31'h0, hold_active});
        chk("grade in normal mode", 32'h0, 32'(grade_out));
        $display("test_normal done");
    endtask : test_normal

    task automatic test_weight();
        int n;
        axi_write(CTRL_OFS, ctrl_word(OPMODE_GRADE_WEIGHT, PRINT_AUTO2, AVG_EIGHT), resp);
        settle(500);
        repeat (HOLD_SIM + 5) @(posedge sys_clk);
        settle(750);
        chk("hold on change", 32'h1, {31'h0, hold_active});
        chk("weight display", 32'd250, 32'(display_digits));
        chk("weight flag", 32'h0, {31'h0, display_is_grade});
        chk("grade in hold", 32'h80, 32'(grade_out));
        settle(600);
        chk("replaced on removal", 32'd150, 32'(display_digits));
        axi_read(DIFF_OFS, rd, resp);
        chk("diff register", 32'd150, rd);
        // fresh edge: count cycles that the hold stands
        repeat (HOLD_SIM + 5) @(posedge sys_clk);
        weight_in <= 900;
        stable_in <= 1'b0;
        repeat (2) @(posedge sys_clk);
        stable_in <= 1'b1;
        n = 0;
        while (hold_active !== 1'b1 && n < 6)
        begin
            @(posedge sys_clk);
            n++;
        end
        n = 0;
        while (hold_active === 1'b1 && n < HOLD_SIM + 10)
        begin
            @(posedge sys_clk);
            n++;
        end
        chk("hold length", 32'(HOLD_SIM), 32'(n));
        chk("grade after hold", 32'h0, 32'(grade_out));
        $display("test_weight done");
    endtask : test_weight

    task automatic test_grade();
        int diffs[7] = '{35, 40, 95, 5, 10, 79, 80};
        int w;
        int g;
        w = 900;
        axi_write(CTRL_OFS, ctrl_word(OPMODE_GRADE_NUMBER, PRINT_AUTO2, AVG_EIGHT), resp);
        // steps come back to back, so each one after the first restarts a running hold
        foreach (diffs[i])
        begin
            w = w + diffs[i];
            g = exp_grade(diffs[i]);
            settle(w);
            chk("grade onehot", g == 0 ? 32'h0 : 32'h1 << (g - 1), 32'(grade_out));
            if (g != 0)
                chk("grade digits", 32'({6{4'(g)}}), 32'(display_digits));
            chk("grade flag", 32'h1, {31'h0, display_is_grade});
        end
        $display("test_grade done");
    endtask : test_grade

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        nrst = 1'b0;
        stable_in = 1'b0;
        weight_in = 32'sh0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        test_regs();
        test_normal();
        test_weight();
        test_grade();
        end_of_test();
    end
endmodule : tb
`default_nettype wire

// >>> weight_grading_hold_logic.sv
// weight grading and hold logic with an AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module weight_grading_hold_logic
    import grading_pkg::*;
#(
    parameter int HOLD_COUNT = HOLD_CYCLES
)(
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // weight front end, same clock domain
    input wire logic signed [31:0] weight_in,
    input wire logic stable_in,
    // grading outputs
    output logic hold_active,
    output logic [NUM_LEVELS-1:0] grade_out,
    output logic accum_enable,
    output logic config_ok,
    output logic [23:0] display_digits,
    output logic display_is_grade,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ----------------------------------------------------------------
    // register bus slave
    // ----------------------------------------------------------------
    logic [31:0] ctrl, next_ctrl;
    logic [31:0] level [NUM_LEVELS];
    logic [31:0] next_level [NUM_LEVELS];
    logic aw_held, next_aw_held, w_held, next_w_held;
    logic [7:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic next_bvalid, next_rvalid, next_awready, next_wready, next_arready;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    ctrl_s cfg;
    logic signed [31:0] diff;

    // each field is picked from its own position; the struct packs them tight, so a plain cast would misalign
    assign cfg = {ctrl[CHECK_LSB +: 2], ctrl[APERTURE_LSB +: 4], ctrl[AVG_LSB +: 4], ctrl[PRINT_LSB +: 2],
                  ctrl[OPMODE_LSB +: 2]};

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
            if (s[b])
                r[b*8 +: 8] = d[b*8 +: 8];
        return r;
    endfunction : merge

    // write side takes address and data in either order, answers once both held
    always_comb
    begin
        logic do_write;
        logic [7:0] a;
        do_write = 1'b0;
        a = 8'h00;
        next_ctrl = ctrl;
        next_level = level;
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready)
            next_bvalid = 1'b0;
        if (next_aw_held && next_w_held && !s_axi_bvalid)
        begin
            do_write = 1'b1;
            a = next_aw_addr;
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = RESP_OKAY;
            if (a == CTRL_OFS)
                next_ctrl = merge(ctrl, next_w_data, next_w_strb);
            else if (a >= LEVEL_BASE_OFS && a <= LEVEL_BASE_OFS + 8'h1C && a[1:0] == 2'b00)
                next_level[a[4:2]] = merge(level[a[4:2]], next_w_data, next_w_strb);
            else if (a != STATUS_OFS && a != DIFF_OFS && a != DISPLAY_OFS)
                next_bresp = RESP_SLVERR;
        end
        next_awready = !next_aw_held && !next_bvalid && !do_write;
        next_wready = !next_w_held && !next_bvalid && !do_write;
    end

    // read side: one read under way, registered data
    always_comb
    begin
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_rvalid && s_axi_rready)
            next_rvalid = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            next_rdata = 32'h0000_0000;
            if (s_axi_araddr == CTRL_OFS)
                next_rdata = {14'h0000, ctrl[17:0]};
            else if (s_axi_araddr == STATUS_OFS)
                next_rdata = {28'h0000000, display_is_grade, config_ok, accum_enable, hold_active};
            else if (s_axi_araddr == DIFF_OFS)
                next_rdata = diff;
            else if (s_axi_araddr == DISPLAY_OFS)
                next_rdata = {8'h00, display_digits};
            else if (s_axi_araddr >= LEVEL_BASE_OFS && s_axi_araddr <= LEVEL_BASE_OFS + 8'h1C
                     && s_axi_araddr[1:0] == 2'b00)
                next_rdata = level[s_axi_araddr[4:2]];
            else
                next_rresp = RESP_SLVERR;
        end
        // address taken whenever no read answer is pending, so arready also rises after reset
        next_arready = !next_rvalid;
    end

    // bus registers
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            ctrl <= CTRL_RESET;
            for (int i = 0; i < NUM_LEVELS; i++)
                level[i] <= LEVEL_RESET;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end
        else
        begin
            ctrl <= next_ctrl;
            level <= next_level;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

    // ----------------------------------------------------------------
    // grading and hold
    // ----------------------------------------------------------------
    logic stable_d, next_stable_d, have_prev, next_have_prev;
    logic signed [31:0] prev_w, next_prev_w, next_diff;
    logic [31:0] hold_cnt, next_hold_cnt;
    logic [NUM_LEVELS-1:0] next_grade_out;
    logic [3:0] grade_num;
    logic next_hold_active, next_accum_enable, next_config_ok, next_display_is_grade;
    logic [23:0] next_display_digits;
    logic grading_mode, take;

    // a new stable sample is the rising edge of the stability flag
    assign take = stable_in && !stable_d;
    assign grading_mode = (cfg.opmode == OPMODE_GRADE_WEIGHT) || (cfg.opmode == OPMODE_GRADE_NUMBER);

    // descending search, first level at or below the difference wins
    // between levels the lower-numbered one reports
    always_comb
    begin
        grade_num = 4'h0;
        for (int i = 0; i < NUM_LEVELS; i++)
            if (grade_num == 4'h0 && $signed(level[NUM_LEVELS-1-i]) <= next_diff)
                grade_num = 4'(NUM_LEVELS - i);
    end

    always_comb
    begin
        next_stable_d = stable_in;
        next_have_prev = have_prev;
        next_prev_w = prev_w;
        next_diff = diff;
        next_hold_cnt = hold_cnt;
        next_display_digits = display_digits;
        next_display_is_grade = display_is_grade;
        next_grade_out = grade_out;
        if (take)
        begin
            next_prev_w = weight_in;
            next_have_prev = 1'b1;
        end
        if (!grading_mode)
            next_hold_cnt = 32'h0;
        else if (take && have_prev)
        begin
            // difference of successive stable readings, magnitude for add or remove
            next_diff = (weight_in >= prev_w) ? weight_in - prev_w : prev_w - weight_in;
            // restart the cycle counter on every new difference
            // a fresh difference replaces the one still on show
            next_hold_cnt = HOLD_COUNT;
        end
        else if (hold_cnt != 32'h0)
            next_hold_cnt = hold_cnt - 32'h1;
        if (grading_mode && take && have_prev)
        begin
            // grade mode display; recompute on restabilising
            // one digit in all six places
            if (cfg.opmode == OPMODE_GRADE_NUMBER)
            begin
                next_display_digits = {6{grade_num}};
                next_display_is_grade = 1'b1;
            end
            // weight mode display of the difference
            else
            begin
                next_display_digits = next_diff[23:0];
                next_display_is_grade = 1'b0;
            end
            next_grade_out = (grade_num == 4'h0) ? '0 : NUM_LEVELS'(1) << (grade_num - 4'h1);
        end
        next_hold_active = next_hold_cnt != 32'h0;
        // grade outputs only while the hold timer runs
        if (!next_hold_active)
            next_grade_out = '0;
        // accumulator only under auto print 2
        next_accum_enable = cfg.print_mode == PRINT_AUTO2;
        // report whether the front end settings suit grading
        next_config_ok = grading_mode && cfg.avg == AVG_EIGHT && cfg.aperture == APERTURE_HALF
                         && cfg.check_mode == CHECK_SETPOINT;
    end

    // grading registers
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            stable_d <= 1'b0;
            have_prev <= 1'b0;
            prev_w <= 32'sh0;
            diff <= 32'sh0;
            hold_cnt <= 32'h0;
            hold_active <= 1'b0;
            grade_out <= '0;
            accum_enable <= 1'b0;
            config_ok <= 1'b0;
            display_digits <= 24'h000000;
            display_is_grade <= 1'b0;
        end
        else
        begin
            stable_d <= next_stable_d;
            have_prev <= next_have_prev;
            prev_w <= next_prev_w;
            diff <= next_diff;
            hold_cnt <= next_hold_cnt;
            hold_active <= next_hold_active;
            grade_out <= next_grade_out;
            accum_enable <= next_accum_enable;
            config_ok <= next_config_ok;
            display_digits <= next_display_digits;
            display_is_grade <= next_display_is_grade;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    hold_start_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (grading_mode && take && have_prev) |=> hold_active && hold_cnt == HOLD_COUNT)
        else $error("hold did not start on new difference");
    outputs_gated_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        !hold_active |-> grade_out == '0)
        else $error("grade output live outside hold");
    accum_sel_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        ##1 accum_enable == ($past(cfg.print_mode) == PRINT_AUTO2))
        else $error("accumulator enable wrong");
    grade_digits_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        display_is_grade |-> display_digits == {6{display_digits[3:0]}})
        else $error("grade digit not repeated");
    hold_count_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (hold_cnt > 32'h1 && !take && grading_mode) |=> hold_cnt == $past(hold_cnt) - 32'h1)
        else $error("hold counter did not decrement");
    diff_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        (grading_mode && take && have_prev && weight_in >= prev_w) |=> diff == $past(weight_in) - $past(prev_w))
        else $error("difference wrong");
    hold_cover_c: cover property (@(posedge sys_clk) disable iff (!nrst) $fell(hold_active));
    regrade_cover_c: cover property (@(posedge sys_clk) disable iff (!nrst) hold_active && take && have_prev);
    grade_cover_c: cover property (@(posedge sys_clk) disable iff (!nrst) display_is_grade && grade_out[7]);

endmodule : weight_grading_hold_logic
`default_nettype wire
